// file: design/tv_audio_pkg.sv
package tv_audio_pkg;

  // ----------------------------------------------------------------
  // Register map (byte index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] FIRST_CONTROL_BYTE_ADDR = 3'h0;  // Volume, mute, deferral
  localparam logic [2:0] SECOND_CONTROL_BYTE_ADDR = 3'h1; // TV audio select
  localparam logic [2:0] THIRD_CONTROL_BYTE_ADDR = 3'h2;  // VCR audio select
  localparam logic [2:0] FOURTH_CONTROL_BYTE_ADDR = 3'h3; // AUX audio select
  localparam logic [2:0] FIFTH_CONTROL_BYTE_ADDR = 3'h4;  // Mute, logic bits
  localparam logic [2:0] STATUS_BYTE_ADDR = 3'h5;         // Read-only status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int COARSE_MSB = 7;      // Coarse volume code, first byte
  localparam int COARSE_LSB = 5;
  localparam int FINE_MSB = 4;        // Fine volume code, first byte
  localparam int FINE_LSB = 2;
  localparam int MUTE_BIT_FIRST = 1;  // Mute request, first byte
  localparam int ZCE_BIT = 0;         // Zero-cross enable, first byte
  localparam int MUTE_BIT_FIFTH = 7;  // Mute request, fifth byte
  localparam int SELECT_MSB = 2;      // Audio select code, bytes 2 to 4
  localparam int SELECT_LSB = 0;
  localparam int LOGIC_MSB = 3;       // Logic output bits, fifth byte
  localparam int ZC_FLAG_BIT = 5;     // Zero-cross flag, status byte
  localparam int POWER_OK_BIT = 4;    // Power-on detect, status byte

  // ----------------------------------------------------------------
  // Values after reset and fixed figures
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_BYTE_RESET = 8'h00;
  localparam logic [2:0] LAST_INPUT_PAIR = 3'h4;       // Codes above mute the pair
  localparam logic [5:0] COARSE_STEP_DB = 6'h08;       // 8 dB per coarse step
  localparam logic signed [7:0] BUFFER_GAIN_DB = 8'sh06;   // Normal +6 dB
  localparam logic signed [7:0] BUFFER_MUTE_DB = -8'sh50;  // Mute -80 dB
  localparam int UNMUTE_WAIT_US = 360;                 // Host wait before un-mute
  localparam int NUM_OUTPUT_PAIRS = 3;                 // TV, VCR, AUX

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Routing of one stereo output pair
  typedef struct packed {
    logic [2:0] input_pair;  // 0..4 selects input pair one to five
    logic pair_mute;         // Pair silenced by select code
  } route_s;

  // Applied TV audio volume and buffer state
  typedef struct packed {
    logic [5:0] coarse_atten_db;  // 0..56 dB
    logic [2:0] fine_atten_db;    // 0..7 dB
    logic tv_mute;                // Output buffer in mute
    logic signed [7:0] buffer_gain_db;
  } tv_volume_s;

endpackage : tv_audio_pkg

// file: design/tv_audio_volume_mute_control.sv
`timescale 1ns/10ps
module tv_audio_volume_mute_control #(
  parameter int ADDR_W = 3  // Register address width
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic zero_cross_pin,
  output tv_audio_pkg::route_s [tv_audio_pkg::NUM_OUTPUT_PAIRS-1:0] route_out,
  output tv_audio_pkg::tv_volume_s tv_volume,
  output logic [3:0] logic_out_bits,
  output logic zero_cross_flag
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Address must reach the status byte
  if (ADDR_W < 3) begin : g_addr_check
    $error("ADDR_W must be at least 3");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0] coarse_req_r;   // Written coarse code
  logic [2:0] fine_req_r;     // Written fine code
  logic mute_req_r;           // Single shared mute request
  logic zce_r;                // Zero-cross deferral enable
  logic [7:0] select_r [tv_audio_pkg::NUM_OUTPUT_PAIRS];  // Select bytes
  logic [3:0] logic_bits_r;   // Logic output bits
  logic pending_r;            // Deferred setting waiting
  logic zc_flag_r;            // Status flag
  logic [7:0] rdata_r;        // Read data register
  logic zc_s1_r;              // Synchroniser stage one
  logic zc_s2_r;              // Synchroniser stage two
  logic zc_s3_r;              // Synchroniser stage three
  logic zc_level_r;           // Filtered crossing level
  tv_audio_pkg::tv_volume_s volume_r;  // Applied volume state
  tv_audio_pkg::route_s [tv_audio_pkg::NUM_OUTPUT_PAIRS-1:0] route_r;  // Routing

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire [2:0] addr_lo = reg_addr[2:0];  // Byte index
  wire addr_hi_zero = (reg_addr >> 3) == '0;  // Upper bits must be clear
  wire sel_first = addr_hi_zero && (addr_lo == tv_audio_pkg::FIRST_CONTROL_BYTE_ADDR);
  wire sel_fifth = addr_hi_zero && (addr_lo == tv_audio_pkg::FIFTH_CONTROL_BYTE_ADDR);
  wire sel_status = addr_hi_zero && (addr_lo == tv_audio_pkg::STATUS_BYTE_ADDR);
  wire wr_first = reg_wr && sel_first;  // First byte written
  wire wr_fifth = reg_wr && sel_fifth;  // Fifth byte written
  // Any volume or mute instruction
  wire vol_wr = wr_first || wr_fifth;

  // ----------------------------------------------------------------
  // Next requested setting
  // ----------------------------------------------------------------
  // Coarse code from first byte
  wire [2:0] coarse_nxt = wr_first ?
    reg_wdata[tv_audio_pkg::COARSE_MSB:tv_audio_pkg::COARSE_LSB] : coarse_req_r;
  // Fine code from first byte
  wire [2:0] fine_nxt = wr_first ?
    reg_wdata[tv_audio_pkg::FINE_MSB:tv_audio_pkg::FINE_LSB] : fine_req_r;
  wire mute_nxt = wr_first ? reg_wdata[tv_audio_pkg::MUTE_BIT_FIRST] :
    (wr_fifth ? reg_wdata[tv_audio_pkg::MUTE_BIT_FIFTH] : mute_req_r);
  wire zce_nxt = wr_first ? reg_wdata[tv_audio_pkg::ZCE_BIT] : zce_r;

  // ----------------------------------------------------------------
  // Zero-cross detection
  // ----------------------------------------------------------------
  // Crossing counts once stages two and three agree
  wire zc_stable = (zc_s2_r == zc_s3_r);
  // Rising edge of the filtered level
  wire zc_event = zc_stable && zc_s3_r && !zc_level_r;

  // ----------------------------------------------------------------
  // Apply decision
  // ----------------------------------------------------------------
  // defer to crossing
  wire apply_now = vol_wr ? (!zce_nxt || zc_event) : (pending_r && zc_event);

  // Volume state to be applied
  // coarse n times 8 dB
  wire [5:0] coarse_db_nxt = 6'(coarse_nxt * tv_audio_pkg::COARSE_STEP_DB);
  wire signed [7:0] gain_nxt = mute_nxt ? tv_audio_pkg::BUFFER_MUTE_DB :
    tv_audio_pkg::BUFFER_GAIN_DB;

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  // First byte reads back as written, except the mute bit, which a fifth byte write also writes
  wire [7:0] first_rd = {coarse_req_r, fine_req_r, mute_req_r, zce_r};
  // Fifth byte holds mute and logic bits
  wire [7:0] fifth_rd = {mute_req_r, 3'h0, logic_bits_r};
  wire [7:0] status_rd = {2'h0, zc_flag_r, 1'h1, 4'h0};
  // Select bytes by index, unmapped reads zero
  wire [7:0] rd_mux =
    sel_first ? first_rd :
    sel_fifth ? fifth_rd :
    sel_status ? status_rd :
    (addr_hi_zero && addr_lo == tv_audio_pkg::SECOND_CONTROL_BYTE_ADDR) ? select_r[0] :
    (addr_hi_zero && addr_lo == tv_audio_pkg::THIRD_CONTROL_BYTE_ADDR) ? select_r[1] :
    (addr_hi_zero && addr_lo == tv_audio_pkg::FOURTH_CONTROL_BYTE_ADDR) ? select_r[2] :
    8'h00;

  // ----------------------------------------------------------------
  // Zero-cross synchroniser and filter
  // ----------------------------------------------------------------
  // Three stages from the pin
  always_ff @(posedge clk) begin
    if (rst) begin
      zc_s1_r <= 1'b0;
      zc_s2_r <= 1'b0;
      zc_s3_r <= 1'b0;
    end else begin
      zc_s1_r <= zero_cross_pin;
      zc_s2_r <= zc_s1_r;
      zc_s3_r <= zc_s2_r;
    end
  end

  // Filtered level follows agreed stages
  always_ff @(posedge clk) begin
    if (rst) begin
      zc_level_r <= 1'b0;
    end else if (zc_stable) begin
      zc_level_r <= zc_s3_r;
    end
  end

  // ----------------------------------------------------------------
  // Requested setting registers
  // ----------------------------------------------------------------
  // newest write replaces pending
  always_ff @(posedge clk) begin
    if (rst) begin
      coarse_req_r <= 3'h0;
      fine_req_r <= 3'h0;
      mute_req_r <= 1'b0;
      zce_r <= 1'b0;
    end else begin
      coarse_req_r <= coarse_nxt;
      fine_req_r <= fine_nxt;
      mute_req_r <= mute_nxt;
      zce_r <= zce_nxt;
    end
  end

  // Logic output bits from fifth byte
  always_ff @(posedge clk) begin
    if (rst) begin
      logic_bits_r <= 4'h0;
    end else if (wr_fifth) begin
      logic_bits_r <= reg_wdata[tv_audio_pkg::LOGIC_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Pending and applied state
  // ----------------------------------------------------------------
  // Pending set by deferred write, cleared on apply
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_r <= 1'b0;
    end else if (apply_now) begin
      pending_r <= 1'b0;
    end else if (vol_wr) begin
      pending_r <= 1'b1;
    end
  end

  // Applied volume changes only on apply
  // fine 0 to 7 dB
  always_ff @(posedge clk) begin
    if (rst) begin
      volume_r <= '{6'h00, 3'h0, 1'b0, tv_audio_pkg::BUFFER_GAIN_DB};
    end else if (apply_now) begin
      volume_r <= '{coarse_db_nxt, fine_nxt, mute_nxt, gain_nxt};
    end
  end

  // clear on write, set on apply
  always_ff @(posedge clk) begin
    if (rst) begin
      zc_flag_r <= 1'b0;
    end else if (apply_now) begin
      // Set wins over a same-cycle clear
      zc_flag_r <= 1'b1;
    end else if (vol_wr) begin
      zc_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output pair routing
  // ----------------------------------------------------------------
  for (genvar p = 0; p < tv_audio_pkg::NUM_OUTPUT_PAIRS; p++) begin : g_pair
    // Select byte for this pair
    wire sel_pair = addr_hi_zero && (addr_lo == 3'(p + 1));
    wire [2:0] code = select_r[p][tv_audio_pkg::SELECT_MSB:tv_audio_pkg::SELECT_LSB];

    // Store written select byte
    always_ff @(posedge clk) begin
      if (rst) begin
        select_r[p] <= tv_audio_pkg::CONTROL_BYTE_RESET;
      end else if (reg_wr && sel_pair) begin
        select_r[p] <= reg_wdata;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        route_r[p] <= '{3'h0, 1'b0};
      end else begin
        route_r[p] <= '{code, code > tv_audio_pkg::LAST_INPUT_PAIR};
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign route_out = route_r;
  assign tv_volume = volume_r;
  assign logic_out_bits = logic_bits_r;
  assign zero_cross_flag = zc_flag_r;

endmodule : tv_audio_volume_mute_control

// file: verif/tv_audio_monitor.sv
`timescale 1ns/10ps
module tv_audio_monitor #(
  parameter int ADDR_W = 3  // Register address width
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic zero_cross_pin,
  input wire tv_audio_pkg::route_s [tv_audio_pkg::NUM_OUTPUT_PAIRS-1:0] route_out,
  input wire tv_audio_pkg::tv_volume_s tv_volume,
  input wire logic [3:0] logic_out_bits,
  input wire logic zero_cross_flag
);
  // ----------------------------------------------------------------
  // Field taps of the write data
  // ----------------------------------------------------------------
  wire logic [2:0] coarse_w = reg_wdata[7:5];  // Coarse code
  wire logic [2:0] fine_w = reg_wdata[4:2];    // Fine code
  wire logic [2:0] sel_w = reg_wdata[2:0];     // Select code
  wire logic [3:0] bits_w = reg_wdata[3:0];    // Logic bits
  wire logic wr0 = reg_wr && reg_addr == tv_audio_pkg::FIRST_CONTROL_BYTE_ADDR;
  wire logic wr1 = reg_wr && reg_addr == tv_audio_pkg::SECOND_CONTROL_BYTE_ADDR;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  status_fixed_a: assert property (reg_rd && reg_addr == 3'h5 |=>
    reg_rdata[7:6] == 2'h0 && reg_rdata[4] && reg_rdata[3:0] == 4'h0)
    else $error("status byte fixed bits wrong");
  select_readback_a: assert property (wr1 ##1 reg_rd && reg_addr == 3'h1 |=>
    reg_rdata == $past(reg_wdata, 2))
    else $error("select byte read back wrong");
  immediate_apply_a: assert property (wr0 && !reg_wdata[0] |=>
    tv_volume.coarse_atten_db == {$past(coarse_w), 3'h0}
    && tv_volume.fine_atten_db == $past(fine_w) && zero_cross_flag)
    else $error("immediate volume not applied");
  deferred_hold_a: assert property (wr0 && reg_wdata[0] && !zero_cross_pin
    && !$past(zero_cross_pin) && !$past(zero_cross_pin, 2) && !$past(zero_cross_pin, 3)
    |=> !zero_cross_flag && $stable(tv_volume))
    else $error("deferred setting applied early");
  volume_quiet_a: assert property (!reg_wr && !zero_cross_pin && !$past(zero_cross_pin)
    && !$past(zero_cross_pin, 2) && !$past(zero_cross_pin, 3) |=> $stable(tv_volume))
    else $error("volume changed without cause");
  mute_gain_a: assert property (tv_volume.buffer_gain_db == (tv_volume.tv_mute ?
    tv_audio_pkg::BUFFER_MUTE_DB : tv_audio_pkg::BUFFER_GAIN_DB))
    else $error("buffer gain does not follow mute");
  route_code_a: assert property (wr1 |=> ##1 route_out[0].pair_mute == ($past(sel_w, 2) > 3'h4)
    && $stable(route_out[1]) && $stable(route_out[2]))
    else $error("route select decode wrong");
  logic_bits_a: assert property (reg_wr && reg_addr == 3'h4 |=>
    logic_out_bits == $past(bits_w))
    else $error("logic bits not updated");
endmodule : tv_audio_monitor

bind tv_audio_volume_mute_control tv_audio_monitor #(.ADDR_W(ADDR_W)) i_monitor (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .zero_cross_pin(zero_cross_pin),
  .route_out(route_out), .tv_volume(tv_volume), .logic_out_bits(logic_out_bits),
  .zero_cross_flag(zero_cross_flag));

// file: verif/tv_audio_host.sv
`timescale 1ns/10ps
module tv_audio_host #(
  parameter int ADDR_W = 3  // Register address width
) (
  input wire logic clk,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // Bus idle at time zero
  initial begin
    reg_addr = '0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write, may follow any strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : wr
  // One-cycle read
  task automatic rd(input logic [ADDR_W-1:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : rd
  // Strobes low for n cycles, n at least one
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic swap_source(input logic [7:0] sel, input logic [3:0] bits);
    wr(3'h4, {4'h8, bits});
    wr(3'h1, sel);
    idle(tv_audio_pkg::UNMUTE_WAIT_US * 40);  // 40 cycles per microsecond
    wr(3'h4, {4'h0, bits});
  endtask : swap_source
  task automatic reissue(input logic [7:0] b);
    wr(3'h0, b & 8'hFE);
  endtask : reissue
endmodule : tv_audio_host

// file: verif/test_tv_audio_volume_mute_control.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD %0t mismatch got %h exp %h", $time, got, exp); end end
module test_tv_audio_volume_mute_control;
  logic clk, rst, zero_cross_pin, rd_pend;  // Stimulus and watcher state
  wire logic [2:0] reg_addr;
  wire logic [7:0] reg_wdata;
  wire logic reg_wr, reg_rd;
  logic [7:0] reg_rdata, b0, d;
  tv_audio_pkg::route_s [2:0] route_out;
  tv_audio_pkg::tv_volume_s tv;
  logic [3:0] logic_out_bits;
  logic zero_cross_flag;
  logic [7:0] exp_q[$];  // Expected read data, oldest first
  logic [7:0] exp_rd;    // Oldest note taken off the queue
  int mismatches, n_checks, i, p, c;
  integer seed;

  tv_audio_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  tv_audio_volume_mute_control i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .zero_cross_pin(zero_cross_pin), .route_out(route_out), .tv_volume(tv),
    .logic_out_bits(logic_out_bits), .zero_cross_flag(zero_cross_flag));

  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Read watcher: data stands one cycle after the strobe
  always @(posedge clk) begin
    if (rd_pend) begin
      exp_rd = exp_q.pop_front();
      `CHK(reg_rdata, exp_rd)
    end
    rd_pend <= reg_rd;
  end

  function automatic tv_audio_pkg::tv_volume_s vol_exp(input logic [7:0] b);
    vol_exp = {b[7:5], 3'h0, b[4:2], b[1],
      b[1] ? tv_audio_pkg::BUFFER_MUTE_DB : tv_audio_pkg::BUFFER_GAIN_DB};
  endfunction : vol_exp
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask : rd_chk
  task automatic settle;
    i_host.idle(1);
    #1;
  endtask : settle
  // Zero-cross pulse of four cycles, then quiet
  task automatic zc;
    i_host.idle(1);
    zero_cross_pin <= 1'b1;
    repeat (4) @(posedge clk);
    zero_cross_pin <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask : zc
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Watchdog against a hang
  initial begin
    #(40000 * 25);
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end
  // Main sequence
  initial begin
    clk = 1'b0; rst = 1'b1; zero_cross_pin = 1'b0; rd_pend = 1'b0; seed = 32'he96a;
    mismatches = 0; n_checks = 0; b0 = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) rd_chk(i[2:0], i == 5 ? 8'h10 : 8'h00);
    settle();
    `CHK(tv, vol_exp(8'h00))
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      b0 = {i[2:0], d[4:1], 1'b0};
      i_host.wr(3'h0, b0);
      rd_chk(3'h5, 8'h30);
      settle();
      `CHK(tv, vol_exp(b0))
    end
    $display("test immediate volume done");
    for (p = 0; p < 3; p++) for (c = 0; c < 8; c++) begin
      d = $random(seed);
      d[2:0] = c[2:0];
      i_host.wr(p[2:0] + 3'h1, d);
      rd_chk(p[2:0] + 3'h1, d);
      settle();
      `CHK(route_out[p].pair_mute, c > 4)
      if (c < 5) `CHK(route_out[p].input_pair, c[2:0])
      `CHK(tv, vol_exp(b0))
    end
    $display("test routing done");
    i_host.wr(3'h0, 8'h6B);
    i_host.wr(3'h0, 8'hA7);
    rd_chk(3'h5, 8'h10);
    settle();
    `CHK(tv, vol_exp(b0))
    zc();
    `CHK(tv, vol_exp(8'hA7))
    rd_chk(3'h5, 8'h30);
    i_host.wr(3'h4, 8'h05);
    settle();
    `CHK(logic_out_bits, 4'h5)
    `CHK(tv, vol_exp(8'hA7))
    zc();
    `CHK(tv, vol_exp(8'hA5))
    rd_chk(3'h0, 8'hA5);
    rd_chk(3'h4, 8'h05);
    i_host.wr(3'h5, 8'hFF);
    rd_chk(3'h5, 8'h30);
    $display("test deferred change done");
    i_host.wr(3'h0, 8'hA7);
    rd_chk(3'h5, 8'h10);
    i_host.reissue(8'hA7);
    rd_chk(3'h5, 8'h30);
    settle();
    `CHK(tv, vol_exp(8'hA6))
    i_host.swap_source(8'h02, 4'hA);
    settle();
    `CHK(tv, vol_exp(8'hA4))
    `CHK(route_out[0].input_pair, 3'h2)
    rd_chk(3'h4, 8'h0A);
    i_host.idle(3);
    $display("test host sequences done");
    print_verdict();
  end
endmodule : test_tv_audio_volume_mute_control
